/* File: hw/xct_pkg.sv */
package xct_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] TUNE_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] SYNTH_TUNE_WORD_OFS = 4'hC;
  // Control register fields
  localparam int CLK_ON_BIT = 0;
  localparam int BAND_LOW_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Tuning register fields: part a in bits 4:0, part b in bits 8:5
  localparam int PART_A_W = 5;
  localparam int PART_B_W = 4;
  localparam logic [8:0] TUNE_RESET = 9'h0D0;
  localparam logic [12:0] TUNE_BASE = 13'hE00;
  // Multiplier times two as an integer (32.5, 64.5, 24.5)
  localparam logic [7:0] MULT2_HIGH = 8'h41;
  localparam logic [7:0] MULT2_LOW = 8'h81;
  localparam logic [7:0] MULT2_LOWBAND = 8'h31;
  // Power modes
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_ACTIVE = 2'h2;
  // Dividers
  localparam int HOST_DIV = 3;
  localparam int CORE_DIV = 16;
  // Amplitude-good must stay stable this many cycles
  localparam int GOOD_FILTER = 4;
endpackage : xct_pkg

/* File: hw/xct_clock_tune.sv */
`timescale 1ns/100ps
// Overview of operation
// RULE_01: Oscillator-good flag rises only after amplitude detector reports enough swing.
// RULE_02: Oscillator-good releases the active-low host reset output.
// RULE_03: Host clock output runs only when clock-enable control bit is set.
// RULE_04: Reset release and clock need supply and core rails good too.
// RULE_05: Part of crystal load capacitance switched off in idle and sleep.
// RULE_06: Tune word equals 3584 plus the two partial tuning fields.
// RULE_07: Software should keep tune word between 3803 and 4053.
// RULE_08: Band pin and band bit select multiplier 32.5, 64.5 or 24.5.
// RULE_09: Host clock is crystal divided by three, near 50% duty; the code holds it high two cycles of three.
// RULE_10: First host clock period after enabling may be truncated.
// RULE_11: Internal timing tick is crystal divided by sixteen.
// RULE_12: Oscillator-good is synchronised and filtered before gating outputs.
module xct_clock_tune (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic oscAmplitudeGood,
  input wire logic supplyOutRailOk,
  input wire logic digitalCoreRailOk,
  input wire logic bandPinSelect,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic hostResetN,
  output logic hostClk,
  output logic coreTick,
  output logic loadCapTrim,
  output logic oscGood
);
  // Synchroniser stages for the three pin inputs
  logic [2:0] syncA_reg, syncB_reg;
  logic [2:0] syncA_next, syncB_next;
  logic [$clog2(xct_pkg::GOOD_FILTER+1)-1:0] filt_reg, filt_next;
  logic good_reg, good_next;
  logic [1:0] div3_reg, div3_next;
  logic [3:0] div16_reg, div16_next;
  logic hostClk_reg, hostClk_next;
  logic tick_reg, tick_next;
  logic rstN_reg, rstN_next;
  logic cap_reg, cap_next;
  logic bandPinMeta_reg, bandPinMeta_next;
  logic bandPin_reg, bandPin_next;
  logic [3:0] ctrl_reg, ctrl_next;
  logic [8:0] tune_reg, tune_next;
  logic [31:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  logic [12:0] tuneWord;
  logic [7:0] mult2;
  logic released;

  // Idle and sleep both drop the partial load cap; shared by logic and checks
  function automatic logic modeSavesPower(input logic [1:0] mode);
    return (mode == xct_pkg::MODE_IDLE) || (mode == xct_pkg::MODE_SLEEP);
  endfunction : modeSavesPower

  // Tune word and band multiplier, combinational from registers
  always_comb begin
    // Part b keeps the weight of its bit position, so the sum spans the full tuning range
    tuneWord = xct_pkg::TUNE_BASE + 13'(tune_reg[xct_pkg::PART_A_W-1:0])
             + (13'(tune_reg[8:xct_pkg::PART_A_W]) << xct_pkg::PART_A_W); // [RULE_06]
    if (ctrl_reg[xct_pkg::BAND_LOW_BIT]) begin
      mult2 = xct_pkg::MULT2_LOWBAND; // [RULE_08]
    end else if (bandPin_reg) begin
      mult2 = xct_pkg::MULT2_HIGH; // [RULE_08]
    end else begin
      mult2 = xct_pkg::MULT2_LOW; // [RULE_08]
    end
    released = good_reg && syncB_reg[1] && syncB_reg[2]; // [RULE_04]
  end

  // Pin synchronisers and the good filter; a glitch resets the count
  always_comb begin
    syncA_next = {digitalCoreRailOk, supplyOutRailOk, oscAmplitudeGood};
    syncB_next = syncA_reg;
    // Band pin is asynchronous too, so it gets two stages like the rails
    bandPinMeta_next = bandPinSelect;
    bandPin_next = bandPinMeta_reg;
    if (!syncB_reg[0]) begin
      filt_next = '0; // [RULE_12]
    end else if (filt_reg != ($bits(filt_reg))'(xct_pkg::GOOD_FILTER)) begin
      filt_next = filt_reg + 1'b1;
    end else begin
      filt_next = filt_reg;
    end
    good_next = (filt_reg == ($bits(filt_reg))'(xct_pkg::GOOD_FILTER)) && syncB_reg[0]; // [RULE_01]
  end

  // Dividers and gated outputs
  always_comb begin
    div3_next = (div3_reg == 2'(xct_pkg::HOST_DIV - 1)) ? 2'h0 : div3_reg + 2'h1; // [RULE_09]
    div16_next = div16_reg + 4'h1; // [RULE_11]
    tick_next = (div16_reg == 4'(xct_pkg::CORE_DIV - 1)); // [RULE_11]
    rstN_next = released; // [RULE_02]
    // Enable is not aligned to the divider, so first period may be short
    hostClk_next = released && ctrl_reg[xct_pkg::CLK_ON_BIT]
                 && (div3_next != 2'h2); // [RULE_03] [RULE_10]
    cap_next = modeSavesPower(ctrl_reg[xct_pkg::MODE_LSB +: 2]); // [RULE_05]
  end

  // Wishbone slave, one wait state, ack drops after one cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    tune_next = tune_reg;
    dat_next = dat_reg;
    ack_next = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      ack_next = 1'b1;
      dat_next = 32'h0;
      case (wb_adr_i)
        xct_pkg::CTRL_OFS: begin
          dat_next = {28'h0, ctrl_reg};
          if (wb_we_i && wb_sel_i[0]) ctrl_next = wb_dat_i[3:0];
        end
        xct_pkg::TUNE_OFS: begin
          dat_next = {23'h0, tune_reg};
          if (wb_we_i && wb_sel_i[0]) tune_next[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) tune_next[8] = wb_dat_i[8];
        end
        xct_pkg::STAT_OFS: dat_next = {27'h0, bandPin_reg, syncB_reg[2], syncB_reg[1], rstN_reg, good_reg};
        // Software may compare against the recommended 3803..4053 range [RULE_07]
        xct_pkg::SYNTH_TUNE_WORD_OFS: dat_next = {8'h0, mult2, 3'h0, tuneWord};
        default: dat_next = 32'h0;
      endcase
    end
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      filt_reg <= '0;
      good_reg <= 1'b0;
      div3_reg <= 2'h0;
      div16_reg <= 4'h0;
      hostClk_reg <= 1'b0;
      tick_reg <= 1'b0;
      rstN_reg <= 1'b0;
      cap_reg <= 1'b1;
      bandPinMeta_reg <= 1'b0;
      bandPin_reg <= 1'b0;
      ctrl_reg <= xct_pkg::CTRL_RESET;
      tune_reg <= xct_pkg::TUNE_RESET;
      dat_reg <= 32'h0;
      ack_reg <= 1'b0;
    end else if (clkEn) begin
      syncA_reg <= syncA_next;
      syncB_reg <= syncB_next;
      filt_reg <= filt_next;
      good_reg <= good_next;
      div3_reg <= div3_next;
      div16_reg <= div16_next;
      hostClk_reg <= hostClk_next;
      tick_reg <= tick_next;
      rstN_reg <= rstN_next;
      cap_reg <= cap_next;
      bandPinMeta_reg <= bandPinMeta_next;
      bandPin_reg <= bandPin_next;
      ctrl_reg <= ctrl_next;
      tune_reg <= tune_next;
      dat_reg <= dat_next;
      ack_reg <= ack_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign hostResetN = rstN_reg;
  assign hostClk = hostClk_reg;
  assign coreTick = tick_reg;
  assign loadCapTrim = cap_reg;
  assign oscGood = good_reg;

  // Checks beside the logic
  good_needs_amp_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && $rose(good_reg) |-> $past(syncB_reg[0], 1)) else $error("good rose without amplitude"); // [RULE_01]
  reset_follows_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && released |=> rstN_reg) else $error("host reset not released"); // [RULE_02]
  clk_gated_a: assert property (@(posedge core_clk) disable iff (rst)
    hostClk_reg |-> rstN_reg || $past(released)) else $error("clock without release"); // [RULE_03]
  rails_needed_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !(syncB_reg[1] && syncB_reg[2]) |=> !rstN_reg) else $error("released with rail low"); // [RULE_04]
  cap_mode_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && ctrl_reg[3:2] == xct_pkg::MODE_ACTIVE |=> !cap_reg) else $error("cap trim in active"); // [RULE_05]
  tune_sum_a: assert property (@(posedge core_clk) disable iff (rst)
    tuneWord == xct_pkg::TUNE_BASE + 13'(tune_reg)) else $error("tune word out of sum"); // [RULE_06]
  div3_period_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && div3_reg == 2'h0 |=> div3_reg == 2'h1) else $error("divide by three broken"); // [RULE_09]
  tick_period_a: assert property (@(posedge core_clk) disable iff (rst)
    tick_reg && clkEn |=> !tick_reg) else $error("tick too long"); // [RULE_11]
  // Tick only at the wrap of the sixteen count
  tick_phase_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_11]
    tick_reg |-> div16_reg == 4'h0) else $error("tick off phase");
  // Divider never reaches the unused fourth code
  div3_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_09]
    clkEn && div3_reg == 2'h2 |=> div3_reg == 2'h0) else $error("divide by three no wrap");
  // Release needs good and both rails one cycle before
  release_cause_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_04]
    $rose(rstN_reg) |-> $past(good_reg && syncB_reg[1] && syncB_reg[2])) else $error("release without cause");
  // Clock pin only starts when software asked for it
  clk_bit_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_03]
    $rose(hostClk_reg) |-> $past(ctrl_reg[xct_pkg::CLK_ON_BIT])) else $error("clock without enable bit");
  // Good rises only after the full filter count
  good_filter_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    $rose(good_reg) |-> $past(filt_reg) == ($bits(filt_reg))'(xct_pkg::GOOD_FILTER)) else $error("filter skipped");
  // A drop of the synced amplitude kills good at once
  good_drop_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_12]
    clkEn && !syncB_reg[0] |=> !good_reg) else $error("good held on glitch");
  // Band bit overrides the pin
  band_bit_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_08]
    ctrl_reg[xct_pkg::BAND_LOW_BIT] |-> mult2 == xct_pkg::MULT2_LOWBAND) else $error("band bit ignored");
  // Low power modes switch the trim on
  cap_idle_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE_05]
    clkEn && modeSavesPower(ctrl_reg[3:2]) |=> cap_reg) else $error("cap trim off in idle");
endmodule : xct_clock_tune

/* File: bench/xct_host_model.sv */
`timescale 1ns/100ps
// Host side: counts clock edges while out of reset
module xct_host_model (
  input wire logic hostClk,
  input wire logic hostResetN,
  output int clkEdges
);
  // Any first edge counts, short or not
  always @(posedge hostClk or negedge hostResetN) begin
    if (!hostResetN) clkEdges <= 0;
    else clkEdges <= clkEdges + 1;
  end
endmodule : xct_host_model

/* File: bench/tb_xct_clock_tune.sv */
`timescale 1ns/100ps
module tb_xct_clock_tune;
  logic core_clk = 0, rst = 1, amp = 0, sup = 0, dig = 0, band = 0, we = 0, cyc = 0, stb = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, dout;
  logic ack, resetN, hClk, tick, trim, good;
  int mismatches = 0, num_checks = 0, edges, ctrl = 0, tune = 'hD0, n, e0, h;
  logic [31:0] seed = 32'hC7719AA4;
  always #50 core_clk = ~core_clk;
  xct_clock_tune uut (.core_clk(core_clk), .rst(rst), .clkEn(1'b1), .oscAmplitudeGood(amp),
    .supplyOutRailOk(sup), .digitalCoreRailOk(dig), .bandPinSelect(band), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dout),
    .wb_ack_o(ack), .hostResetN(resetN), .hostClk(hClk), .coreTick(tick), .loadCapTrim(trim), .oscGood(good));
  xct_host_model host (.hostClk(hClk), .hostResetN(resetN), .clkEdges(edges));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Part b carries the weight of its bit position
  function automatic logic [31:0] fexp();
    int m;
    m = ctrl[1] ? 'h31 : (band ? 'h41 : 'h81);
    return (m << 16) | (3584 + (tune & 31) + ((tune >> 5) & 15) * 32);
  endfunction : fexp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // Classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic [3:0] a, input logic w, input int d);
    adr <= a; we <= w; wd <= d; cyc <= 1; stb <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 50);
    rdat = dout;
    cyc <= 0; stb <= 0;
    if (ack !== 1'b1) begin mismatches++; end_of_test(); end
    @(posedge core_clk);
  endtask : wb
  task automatic rd(input logic [3:0] a, input int e);
    wb(a, 0, 0);
    chk(rdat, e);
  endtask : rd
  initial begin #3000000; mismatches++; end_of_test(); end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rd(4'h0, 0); rd(4'h4, 'hD0); rd(4'h2, 0); chk(resetN, 0); chk(trim, 1);
    for (int i = 0; i < 12; i++) begin
      tune = 219 + rnd() % 251;
      ctrl = (i % 3 == 2) << 1;
      band <= (i / 3) % 2;
      wb(4'h4, 1, tune); wb(4'h0, 1, ctrl); repeat (3) @(posedge core_clk);
      rd(4'hC, fexp());
    end
    for (int m = 0; m < 4; m++) begin
      ctrl = m << 2; wb(4'h0, 1, ctrl); repeat (2) @(posedge core_clk);
      chk(trim, m < 2);
    end
    sup <= 1; dig <= 1; amp <= 1; repeat (2) @(posedge core_clk); amp <= 0;
    repeat (20) @(posedge core_clk);
    chk(resetN, 0);
    amp <= 1;
    n = 0;
    while (resetN !== 1'b1 && n < 40) begin @(posedge core_clk); n++; end
    chk(n >= 2 + xct_pkg::GOOD_FILTER && n < 40, 1); chk(good, 1);
    rd(4'h8, (band << 4) | 15); repeat (30) @(posedge core_clk); chk(edges, 0);
    wb(4'h0, 1, ctrl | 1); e0 = edges; h = 0;
    repeat (30) begin @(posedge core_clk); #1 h += hClk; end
    chk(edges - e0, 10); chk(h, 20);
    h = 0;
    repeat (64) begin @(posedge core_clk); #1 h += tick; end
    chk(h, 4);
    sup <= 0; repeat (10) @(posedge core_clk); e0 = edges; repeat (12) @(posedge core_clk);
    chk(resetN, 0); chk(edges, 0); chk(e0, 0);
    end_of_test();
  end
endmodule : tb_xct_clock_tune
